// ### byte_alu.sv
`timescale 1ns/1ns
`default_nettype none
module byte_alu
  import byte_op_pkg::*;
(
  input  wire logic     [7:0] acc,     // Accumulator
  input  wire logic     [7:0] fval,    // File register read value
  input  wire flags_t         fin,     // Flags in
  input  wire alu_op_t        op,      // Operation
  output var  logic     [7:0] res,     // Result
  output var  flags_t         fout     // Flags out
);

  always_comb
  begin
    logic [8:0] sum;
    logic [4:0] lo;
    logic       cin;
    cin  = (op == ALU_ADDC) ? fin.c : 1'b0;
    sum  = {1'b0, acc} + {1'b0, fval} + {8'h00, cin};
    lo   = {1'b0, acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, cin};
    res  = fval;
    fout = fin;
    case (op)
      ALU_ADD, ALU_ADDC:
      begin
        res     = sum[7:0];
        fout.c  = sum[8];
        fout.dc = lo[4];
        fout.z  = (sum[7:0] == 8'h00);
      end
      ALU_AND:
      begin
        res    = acc & fval;
        fout.z = ((acc & fval) == 8'h00);
      end
      ALU_OR:
      begin
        res    = acc | fval;
        fout.z = ((acc | fval) == 8'h00);
      end
      ALU_ASR:
      begin
        res    = {fval[7], fval[7:1]};
        fout.c = fval[0];
        fout.z = ({fval[7], fval[7:1]} == 8'h00);
      end
      ALU_LSL:
      begin
        res    = {fval[6:0], 1'b0};
        fout.c = fval[7];
        fout.z = (fval[6:0] == 7'h00);
      end
      ALU_LSR:
      begin
        res    = {1'b0, fval[7:1]};
        fout.c = fval[0];
        fout.z = (fval[7:1] == 7'h00);
      end
      ALU_RL:
      begin
        res    = {fval[6:0], fin.c};
        fout.c = fval[7];
      end
      ALU_RR:
      begin
        res    = {fin.c, fval[7:1]};
        fout.c = fval[0];
      end
      default:
      begin
        res  = fval;
        fout = fin;
      end
    endcase
  end

endmodule : byte_alu
`default_nettype wire

// ### byte_op_instruction_decoder.sv
// Contract
// - Each instruction is one 14-bit word with opcode and all operands.
// - Opcodes sort into byte, bit, and literal/control classes.
// - One cycle per instruction; both subroutine calls take two.
// - All three returns take two instruction cycles.
// - Jumps, and skips when taken, take two instruction cycles.
// - Indirect access while pointer selects program memory adds one cycle.
// - Each instruction cycle is four oscillator clock periods.
// - File instructions read the register, modify, then store the result.
// - Destination bit zero writes accumulator, one writes file register.
// - File address field is seven bits, 0x00 to 0x7F.
// - Bit field picks one of eight bits in the register.
// - Don't-care instruction bits do not change the decoded operation.
// - Pointer number field picks pointer pair zero or one; ptr_sel is left unused, the file address picks the pointer.
// - 00 0111 adds, 11 1101 adds with carry; C, DC, Z updated.
// - 00 0101 is AND, 00 0100 is OR; AND updates zero.
// - 11 0111 ASR, 11 0101 LSL, 11 0110 LSR; C and Z.
// - 00 1101 rotate left, 00 1100 rotate right through carry.
// - The extra cycle of a two-cycle instruction executes as no-op.
`timescale 1ns/1ns
`default_nettype none
module byte_op_instruction_decoder
  import byte_op_pkg::*;
(
  input  wire logic                  clk_sys,     // Oscillator clock
  input  wire logic                  rst_n,       // Sync reset, low
  input  wire logic [INSN_W-1:0]     insn,        // Fetched word
  input  wire logic [DATA_W-1:0]     file_rdata,  // File read data
  input  wire logic                  ptr0_prog,   // Pointer 0 MSb set
  input  wire logic                  ptr1_prog,   // Pointer 1 MSb set
  input  wire logic                  skip_zero,   // Inc/dec result zero
  output logic                       fetch,       // Word taken this edge
  output logic [1:0]                 phase,       // Oscillator phase
  output logic                       file_re,     // File read strobe
  output logic [FADDR_W-1:0]         file_addr,   // File address
  output logic                       file_we,     // File write strobe
  output logic [DATA_W-1:0]          file_wdata,  // File write data
  output logic [DATA_W-1:0]          acc,         // Accumulator
  output byte_op_pkg::flags_t        flags,       // C, DC, Z
  output byte_op_pkg::insn_class_t   cls,         // Current class
  output logic                       idle_cycle,  // No-op cycle running
  output logic                       stall        // Indirect stall cycle running
);

  // ----------------------------------------------------------------
  // Assertion defaults
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  decoded_t         dec;
  logic [7:0]       alu_res;
  flags_t           alu_flags;

  insn_decode u_dec
  (
    .insn (insn),
    .dec  (dec)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum {S_EXEC, S_INDIRECT, S_NOP} seq_t;

  seq_t             st_q, st_d;
  logic [1:0]       ph_q, ph_d;
  decoded_t         cur_q, cur_d;
  logic [7:0]       rd_q, rd_d;
  logic [7:0]       acc_q, acc_d;
  flags_t           fl_q, fl_d;
  logic             fetch_q, fetch_d;
  logic             re_q, re_d;
  logic             we_q, we_d;
  logic [7:0]       wd_q, wd_d;
  logic [6:0]       fa_q, fa_d;
  logic             last_ph;
  logic             ind_prog;
  logic             bit_val;
  logic             skip_taken;
  logic             idle_q, idle_d;
  logic             stall_q, stall_d;

  byte_alu u_alu
  (
    .acc  (acc_q),
    .fval (rd_q),
    .fin  (fl_q),
    .op   (cur_q.op),
    .res  (alu_res),
    .fout (alu_flags)
  );

  assign last_ph  = (ph_q == 2'(PHASES - 1));
  // Indirect access register picked by the address field
  assign ind_prog = (dec.faddr == INDIRECT_0 && ptr0_prog)
                 || (dec.faddr == INDIRECT_1 && ptr1_prog);
  assign bit_val  = rd_q[cur_q.bitsel];
  assign skip_taken = cur_q.cond_skip
                   && ((cur_q.cls == CL_BIT)
                       ? (bit_val == cur_q.skip_on_set)
                       : skip_zero);

  always_comb
  begin
    st_d    = st_q;
    ph_d    = ph_q + 2'd1;
    cur_d   = cur_q;
    rd_d    = rd_q;
    acc_d   = acc_q;
    fl_d    = fl_q;
    fetch_d = 1'b0;
    re_d    = 1'b0;
    we_d    = 1'b0;
    wd_d    = wd_q;
    fa_d    = fa_q;
    // Strobe the read in phase 2 so the value is stable by the modify phase
    if (ph_q == 2'd1 && st_q == S_EXEC && cur_q.uses_file)
    begin
      re_d = 1'b1;
      fa_d = cur_q.faddr;
    end
    if (ph_q == 2'd2 && st_q == S_EXEC && cur_q.uses_file)
    begin
      rd_d = file_rdata;
    end
    if (last_ph)
    begin
      case (st_q)
        S_EXEC:
        begin
          if (cur_q.op != ALU_NONE)
          begin
            fl_d = alu_flags;
            if (cur_q.dest_file)
            begin
              we_d = 1'b1;
              wd_d = alu_res;
            end
            else
            begin
              acc_d = alu_res;
            end
          end
          if (cur_q.two_cycle || skip_taken)
          begin
            st_d = S_NOP;
          end
          else
          begin
            fetch_d = 1'b1;
            cur_d   = dec;
            st_d    = (dec.uses_file && ind_prog)
                      ? S_INDIRECT : S_EXEC;
          end
        end
        S_INDIRECT:
        begin
          // Stall runs first; the word then executes as usual
          st_d = S_EXEC;
        end
        S_NOP:
        begin
          // Second cycle retires nothing
          fetch_d = 1'b1;
          cur_d   = dec;
          st_d    = (dec.uses_file && ind_prog)
                    ? S_INDIRECT : S_EXEC;
        end
        default:
        begin
          st_d = S_EXEC;
        end
      endcase
    end
    // Status levels follow the next state so they leave a flop
    idle_d  = (st_d == S_NOP);
    stall_d = (st_d == S_INDIRECT);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q    <= S_NOP;
      ph_q    <= 2'd0;
      cur_q   <= '0;
      rd_q    <= 8'h00;
      acc_q   <= ACC_RST;
      fl_q    <= '0;
      fetch_q <= 1'b0;
      re_q    <= 1'b0;
      we_q    <= 1'b0;
      wd_q    <= 8'h00;
      fa_q    <= 7'h00;
      idle_q  <= 1'b1;
      stall_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      ph_q    <= ph_d;
      cur_q   <= cur_d;
      rd_q    <= rd_d;
      acc_q   <= acc_d;
      fl_q    <= fl_d;
      fetch_q <= fetch_d;
      re_q    <= re_d;
      we_q    <= we_d;
      wd_q    <= wd_d;
      fa_q    <= fa_d;
      idle_q  <= idle_d;
      stall_q <= stall_d;
    end
  end

  assign fetch      = fetch_q;
  assign phase      = ph_q;
  assign file_re    = re_q;
  assign file_addr  = fa_q;
  assign file_we    = we_q;
  assign file_wdata = wd_q;
  assign acc        = acc_q;
  assign flags      = fl_q;
  assign cls        = cur_q.cls;
  assign idle_cycle = idle_q;
  assign stall      = stall_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fetch_spacing: assert property (fetch_q |=> !fetch_q [*3])
    else $error("fetch closer than four clocks");

  a_phase_step: assert property (1'b1 |=> ph_q == $past(ph_q) + 2'd1)
    else $error("phase did not advance by one");

  a_one_cycle: assert property (
    (last_ph && st_q == S_EXEC && !cur_q.two_cycle && !skip_taken)
      |=> fetch_q)
    else $error("one-cycle op did not fetch");

  a_two_cycle_nop: assert property (
    (last_ph && st_q == S_EXEC && cur_q.two_cycle)
      |=> (st_q == S_NOP) [*4])
    else $error("two-cycle op did not idle");

  a_skip_idle: assert property (
    (last_ph && st_q == S_EXEC && skip_taken)
      |=> (st_q == S_NOP) [*4])
    else $error("taken skip did not idle");

  a_nop_no_write: assert property ((st_q == S_NOP) |-> ##1 !we_q)
    else $error("write during idle cycle");

  a_nop_acc_hold: assert property (
    (st_q == S_NOP)
      |=> $stable(acc_q))
    else $error("accumulator changed during idle cycle");

  a_acc_dest_zero: assert property (
    (last_ph && st_q == S_EXEC && cur_q.op != ALU_NONE
      && !cur_q.dest_file) |=> !we_q && acc_q == $past(alu_res))
    else $error("accumulator destination wrong");

  a_file_dest_one: assert property (
    (last_ph && st_q == S_EXEC && cur_q.op != ALU_NONE
      && cur_q.dest_file) |=> we_q && file_wdata == $past(alu_res))
    else $error("file destination wrong");

  a_read_phase: assert property (
    (ph_q == 2'd1 && st_q == S_EXEC && cur_q.uses_file)
      |=> re_q && fa_q == cur_q.faddr)
    else $error("file not read in phase two");

  a_read_before_wr: assert property (we_q |-> $past(re_q, 2))
    else $error("file written without read");

  a_indirect_extra: assert property (
    (st_q == S_INDIRECT && ph_q == 2'd0)
      |-> (st_q == S_INDIRECT) [*4] ##1 st_q == S_EXEC)
    else $error("indirect stall not one cycle");

  a_stall_no_read: assert property (
    (st_q == S_INDIRECT) |=> !re_q)
    else $error("file read during indirect stall");

  a_zero_flag: assert property (
    (last_ph && st_q == S_EXEC && cur_q.op == ALU_AND)
      |=> fl_q.z == ($past(acc_q & rd_q) == 8'h00))
    else $error("zero flag wrong after and");

  a_rotate_carry: assert property (
    (last_ph && st_q == S_EXEC && cur_q.op == ALU_RL)
      |=> fl_q.c == $past(rd_q[7]) && fl_q.z == $past(fl_q.z))
    else $error("rotate flags wrong");

endmodule : byte_op_instruction_decoder
`default_nettype wire

// ### byte_op_instruction_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
module byte_op_instruction_decoder_bench;
  import byte_op_pkg::*;

  logic        clk_sys;
  logic        rst_n;
  logic [13:0] insn;
  logic [7:0]  file_rdata;
  logic        ptr0_prog;
  logic        ptr1_prog;
  logic        skip_zero;
  logic        fetch;
  logic [1:0]  phase;
  logic        file_re;
  logic [6:0]  file_addr;
  logic        file_we;
  logic [7:0]  file_wdata;
  logic [7:0]  acc;
  flags_t      flags;
  insn_class_t cls;
  logic        idle_cycle;
  logic        stall;
  int          bad_count;
  int          checks;
  int          cycles;
  logic [7:0]  ea;
  flags_t      ef;

  byte_op_instruction_decoder u_dut (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .insn       (insn),
    .file_rdata (file_rdata),
    .ptr0_prog  (ptr0_prog),
    .ptr1_prog  (ptr1_prog),
    .skip_zero  (skip_zero),
    .fetch      (fetch),
    .phase      (phase),
    .file_re    (file_re),
    .file_addr  (file_addr),
    .file_we    (file_we),
    .file_wdata (file_wdata),
    .acc        (acc),
    .flags      (flags),
    .cls        (cls),
    .idle_cycle (idle_cycle),
    .stall      (stall)
  );

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Returns {c, dc, z, result}
  function automatic logic [10:0] alu_model(input logic [5:0] op,
      input logic [7:0] a, input logic [7:0] f, input flags_t fi);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    flags_t     fo;
    fo = fi;
    r  = f;
    case (op)
      OP_ADD, OP_ADDC:
      begin
        s = {1'b0, a} + {1'b0, f} + {8'h00, (op == OP_ADDC) & fi.c};
        h = {1'b0, a[3:0]} + {1'b0, f[3:0]} + {4'h0, (op == OP_ADDC) & fi.c};
        r = s[7:0];
        fo.c  = s[8];
        fo.dc = h[4];
      end
      OP_AND: r = a & f;
      OP_OR:  r = a | f;
      OP_ASR: begin r = {f[7], f[7:1]}; fo.c = f[0]; end
      OP_LSL: begin r = {f[6:0], 1'b0}; fo.c = f[7]; end
      OP_LSR: begin r = {1'b0, f[7:1]}; fo.c = f[0]; end
      OP_RL:  begin r = {f[6:0], fi.c}; fo.c = f[7]; end
      OP_RR:  begin r = {fi.c, f[7:1]}; fo.c = f[0]; end
      default: r = f;
    endcase
    // Rotates leave zero alone
    if (op != OP_RL && op != OP_RR)
      fo.z = (r == 8'h00);
    return {fo, r};
  endfunction : alu_model

  // Present a word for the next phase-3 edge, then fall back to no-op
  task automatic take(input logic [13:0] w, input logic [7:0] rd,
      input logic p0, input logic p1, input logic sz);
    int n;
    n = 0;
    while (phase !== 2'h3 && n < 8)
    begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    check(16'(phase), 16'h0003);
    insn       = w;
    file_rdata = rd;
    ptr0_prog  = p0;
    ptr1_prog  = p1;
    skip_zero  = sz;
    @(posedge clk_sys);
    #2;
    insn = 14'h0000;
    check(16'(fetch), 16'h0001);
  endtask : take

  task automatic run_alu(input logic [5:0] op, input logic d,
      input logic [6:0] f, input logic [7:0] rd);
    logic [10:0] m;
    m = alu_model(op, ea, rd, ef);
    take({op, d, f}, rd, 1'b0, 1'b0, 1'b0);
    check(16'(cls), 16'(CL_BYTE));
    for (int i = 1; i <= 4; i++)
    begin
      @(posedge clk_sys);
      #2;
      check(16'(phase), 16'(i % 4));
      if (i == 2)
      begin
        check(16'(file_re), 16'h0001);
        check(16'(file_addr), 16'(f));
      end
    end
    check(16'(file_we), 16'(d));
    if (d)
      check(16'(file_wdata), 16'(m[7:0]));
    else
      ea = m[7:0];
    check(16'(acc), 16'(ea));
    ef = m[10:8];
    check({13'h0000, flags}, {13'h0000, ef});
  endtask : run_alu

  // Clocks from take to next take; class 3 means not compared
  task automatic timed(input logic [13:0] w, input logic [7:0] rd,
      input logic p0, input logic p1, input logic sz, input int cyc,
      input logic [1:0] ecls);
    int   n;
    logic idl;
    logic stl;
    idl = 1'b0;
    stl = 1'b0;
    n   = 0;
    take(w, rd, p0, p1, sz);
    if (ecls != 2'h3)
      check(16'(cls), 16'(ecls));
    do
    begin
      @(posedge clk_sys);
      #2;
      n++;
      idl = idl | idle_cycle;
      stl = stl | stall;
    end while (fetch !== 1'b1 && n < 16);
    // Code 3: one-cycle op plus the indirect stall, eight clocks
    check(16'(n), 16'((cyc == 3) ? 8 : 4 * cyc));
    check(16'(idl), 16'(cyc == 2));
    check(16'(stl), 16'(cyc == 3));
  endtask : timed

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n      = 1'b0;
    insn       = 14'h0000;
    file_rdata = 8'h00;
    ptr0_prog  = 1'b0;
    ptr1_prog  = 1'b0;
    skip_zero  = 1'b0;
    bad_count  = 0;
    checks     = 0;
    cycles     = 0;
    ea         = ACC_RST;
    ef         = '0;
    repeat (2) @(posedge clk_sys);
    #2;
    check(16'(acc), 16'(ACC_RST));
    check({12'h000, phase, fetch, file_we}, 16'h0000);
    rst_n = 1'b1;
    run_alu(OP_OR,   1'b0, 7'h10, 8'h3c);
    run_alu(OP_ADD,  1'b1, 7'h7f, 8'hd0);
    run_alu(OP_ADDC, 1'b0, 7'h20, 8'hc3);
    run_alu(OP_AND,  1'b1, 7'h21, 8'hff);
    run_alu(OP_OR,   1'b0, 7'h22, 8'h81);
    run_alu(OP_ASR,  1'b1, 7'h23, 8'h81);
    run_alu(OP_LSL,  1'b1, 7'h24, 8'h80);
    run_alu(OP_LSR,  1'b0, 7'h25, 8'h01);
    run_alu(OP_RL,   1'b1, 7'h26, 8'h55);
    run_alu(OP_RR,   1'b1, 7'h27, 8'h02);
    run_alu(OP_ADD,  1'b0, 7'h28, 8'h0f);
    timed(14'h2000,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h2);
    timed(W_CALLACC, 8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h3);
    timed(W_RETURN,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h3);
    timed(W_IRQEXIT, 8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h3);
    timed(14'h3400,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h2);
    timed(14'h2800,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h2);
    timed(14'h3200,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h2);
    timed(W_RELACC,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h3);
    timed(14'h1f90,  8'h80, 1'b0, 1'b0, 1'b0, 2, 2'h1);
    timed(14'h1f90,  8'h7f, 1'b0, 1'b0, 1'b0, 1, 2'h1);
    timed(14'h1990,  8'h00, 1'b0, 1'b0, 1'b0, 2, 2'h1);
    timed(14'h1990,  8'h08, 1'b0, 1'b0, 1'b0, 1, 2'h1);
    timed(14'h0b90,  8'h01, 1'b0, 1'b0, 1'b1, 2, 2'h0);
    timed(14'h0b90,  8'h05, 1'b0, 1'b0, 1'b0, 1, 2'h0);
    timed(14'h0f90,  8'hff, 1'b0, 1'b0, 1'b1, 2, 2'h0);
    timed(14'h0780,  8'h11, 1'b1, 1'b0, 1'b0, 3, 2'h0);
    timed(14'h0581,  8'h11, 1'b0, 1'b1, 1'b0, 3, 2'h0);
    timed(14'h0781,  8'h11, 1'b1, 1'b0, 1'b0, 1, 2'h0);
    timed(14'h0710,  8'h11, 1'b1, 1'b1, 1'b0, 1, 2'h0);
    timed(14'h0000,  8'h00, 1'b0, 1'b0, 1'b0, 1, 2'h3);
    end_sim();
  end

endmodule : byte_op_instruction_decoder_bench
`default_nettype wire

// ### byte_op_pkg.sv
package byte_op_pkg;

  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int INSN_W      = 14;
  localparam int FADDR_W     = 7;
  localparam int DEST_POS    = 7;
  localparam int BIT_LSB     = 7;
  localparam int PTR_POS     = 6;
  localparam int OPC_LSB     = 8;
  localparam int CLS_LSB     = 12;
  localparam int DATA_W      = 8;
  localparam int PHASES      = 4;

  // ----------------------------------------------------------------
  // Class codes (top two bits)
  // ----------------------------------------------------------------
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_JMP  = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;

  // ----------------------------------------------------------------
  // Upper opcode fields: six bits, five for OP_RELJMP, two for bit ops
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_ADD      = 6'h07;
  localparam logic [5:0] OP_ADDC     = 6'h3D;
  localparam logic [5:0] OP_AND      = 6'h05;
  localparam logic [5:0] OP_OR       = 6'h04;
  localparam logic [5:0] OP_ASR      = 6'h37;
  localparam logic [5:0] OP_LSL      = 6'h35;
  localparam logic [5:0] OP_LSR      = 6'h36;
  localparam logic [5:0] OP_RL       = 6'h0D;
  localparam logic [5:0] OP_RR       = 6'h0C;
  localparam logic [5:0] OP_DECSKIP  = 6'h0B;
  localparam logic [5:0] OP_INCSKIP  = 6'h0F;
  localparam logic [5:0] OP_RETLIT   = 6'h34;
  localparam logic [4:0] OP_RELJMP   = 5'h19;
  localparam logic [1:0] BITOP_CLR   = 2'h2;
  localparam logic [1:0] BITOP_SET   = 2'h3;

  // Full-word control opcodes
  localparam logic [13:0] W_RETURN   = 14'h0008;
  localparam logic [13:0] W_IRQEXIT  = 14'h0009;
  localparam logic [13:0] W_CALLACC  = 14'h000A;
  localparam logic [13:0] W_RELACC   = 14'h000B;

  // Indirect access register locations, one per pointer
  localparam logic [6:0] INDIRECT_0  = 7'h00;
  localparam logic [6:0] INDIRECT_1  = 7'h01;

  // Reset values
  localparam logic [7:0] ACC_RST     = 8'h00;

  typedef enum logic [1:0] {CL_BYTE, CL_BIT, CL_LITCTL} insn_class_t;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADDC, ALU_AND, ALU_OR, ALU_ASR,
    ALU_LSL, ALU_LSR, ALU_RL, ALU_RR
  } alu_op_t;

  typedef struct packed {
    insn_class_t  cls;
    alu_op_t      op;
    logic         dest_file;
    logic [6:0]   faddr;
    logic [2:0]   bitsel;
    logic         ptr_sel;
    logic         two_cycle;
    logic         cond_skip;
    logic         skip_on_set;
    logic         uses_file;
  } decoded_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } flags_t;

  typedef struct packed {
    logic       we_file;
    logic       we_acc;
    logic [6:0] addr;
    logic [7:0] data;
  } result_t;

endpackage : byte_op_pkg

// ### insn_decode.sv
`timescale 1ns/1ns
`default_nettype none
module insn_decode
  import byte_op_pkg::*;
(
  input  wire logic [13:0] insn,    // Instruction word
  output var  decoded_t    dec      // Decoded fields
);

  always_comb
  begin
    logic [5:0] up;
    up = insn[13:8];
    dec = '0;
    dec.faddr     = insn[FADDR_W-1:0];
    dec.dest_file = insn[DEST_POS];
    dec.bitsel    = insn[BIT_LSB+2:BIT_LSB];
    dec.ptr_sel   = insn[PTR_POS];
    dec.op        = ALU_NONE;
    // Class from the top bits; 11 xxxx byte ops are re-sorted below
    case (insn[13:12])
      CLS_BYTE: dec.cls = CL_BYTE;
      CLS_BIT:  dec.cls = CL_BIT;
      default:  dec.cls = CL_LITCTL;
    endcase
    dec.uses_file = (insn[13:12] != CLS_JMP);
    case (up)
      OP_ADD:  dec.op = ALU_ADD;
      OP_ADDC: dec.op = ALU_ADDC;
      OP_AND:  dec.op = ALU_AND;
      OP_OR:   dec.op = ALU_OR;
      OP_ASR:  dec.op = ALU_ASR;
      OP_LSL:  dec.op = ALU_LSL;
      OP_LSR:  dec.op = ALU_LSR;
      OP_RL:   dec.op = ALU_RL;
      OP_RR:   dec.op = ALU_RR;
      default: dec.op = ALU_NONE;
    endcase
    if (dec.op != ALU_NONE)
    begin
      dec.cls = CL_BYTE;
    end
    if (insn[13:12] == CLS_LIT)
    begin
      dec.uses_file = (dec.op != ALU_NONE);
    end
    // Fixed-cost branches, calls and returns
    if (insn[13:12] == CLS_JMP || up == OP_RETLIT
        || insn[13:9] == OP_RELJMP
        || insn == W_RETURN || insn == W_IRQEXIT
        || insn == W_CALLACC || insn == W_RELACC)
    begin
      dec.two_cycle = 1'b1;
      dec.uses_file = 1'b0;
    end
    if (up == OP_DECSKIP || up == OP_INCSKIP)
    begin
      dec.cond_skip = 1'b1;
    end
    if (insn[13:12] == CLS_BIT && insn[11:10] == BITOP_CLR)
    begin
      dec.cond_skip = 1'b1;
    end
    if (insn[13:12] == CLS_BIT && insn[11:10] == BITOP_SET)
    begin
      dec.cond_skip   = 1'b1;
      dec.skip_on_set = 1'b1;
    end
    if (insn[13:8] == 6'h00 && insn[7:4] == 4'h0)
    begin
      dec.uses_file = 1'b0;
    end
  end

endmodule : insn_decode
`default_nettype wire
